/* File: core/gsc_guest_state_entry_checker.sv */
// Guest-state entry checker with an AXI4-Lite register file
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "gsc_map.svh"
module gsc_guest_state_entry_checker
  import gsc_pkg::*;
#(
  parameter int LIN_W = 48,
  parameter logic [31:0] DBG_RSVD = 32'hFFFF_C03C,
  parameter logic [31:0] XFEAT_RSVD = 32'hFFFF_F2FE
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [8:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [8:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic entry_done, // Verdict pulse
  output logic entry_fail, // Last verdict failed
  output logic host_reload // Reload host state pulse
);

  // Parameter sanity
  if (LIN_W < 33 || LIN_W > 63) begin : g_bad_lin
    $error("LIN_W must lie in 33..63");
  end

  gsc_word_t regs [0:`GSC_NREGS-1];
  logic aw_full;
  logic w_full;
  logic [6:0] aw_idx;
  gsc_word_t w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic start_wr;
  logic start_q;
  logic done;
  logic [`GSC_FAIL_W-1:0] fail_vec;
  logic [`GSC_FAIL_W-1:0] fail_code;
  gsc_word_t rd_word;
  logic [6:0] ar_idx;

  // Address decode, used by both channels
  function automatic logic is_mapped(input logic [6:0] idx);
    is_mapped = (idx <= `GSC_IDX_LAST) ||
      (idx >= `GSC_IDX_SEG0 && idx < `GSC_IDX_SEG_END && idx[2:0] < `GSC_SEG_FIELDS);
  endfunction : is_mapped

  function automatic logic is_writable(input logic [6:0] idx);
    is_writable = is_mapped(idx) && idx != `GSC_IDX_STATUS && idx != `GSC_IDX_FAILCODE;
  endfunction : is_writable

  function automatic gsc_word_t merge(input gsc_word_t old, input gsc_word_t d,
                                      input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  // Address is canonical when the top bits all match
  function automatic logic canon(input gsc_word_t hi, input gsc_word_t lo);
    logic [63:0] a;
    a = {hi, lo};
    canon = (&a[63:LIN_W-1]) || !(|a[63:LIN_W-1]);
  endfunction : canon

  // Granularity against limit field
  function automatic logic g_bad(input gsc_word_t lim, input logic g);
    g_bad = (!(&lim[11:0]) && g) || ((|lim[31:20]) && !g);
  endfunction : g_bad

  // Upper address bits at or beyond the physical width
  function automatic logic [19:0] pa_over(input gsc_word_t w);
    for (int i = 0; i < 20; i++) begin
      pa_over[i] = (32'(i) + 32'd32) >= w;
    end
  endfunction : pa_over

  // Handshake outputs
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign start_wr = wr_fire && aw_idx == `GSC_IDX_CTRL && w_strb[0] &&
                    w_data[`GSC_CTL_START];

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_idx <= 7'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_idx <= s_axi_awaddr[8:2];
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GSC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_idx) ? `GSC_RESP_OKAY : `GSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `GSC_NREGS; i++) begin
        regs[i] <= 32'h0000_0000;
      end
      regs[`GSC_IDX_ZERO_FX1] <= `GSC_FX1_RST;
      regs[`GSC_IDX_FOUR_FX1] <= `GSC_FX1_RST;
      regs[`GSC_IDX_PA_WIDTH] <= `GSC_PA_WIDTH_RST;
    end else if (wr_fire && is_writable(aw_idx)) begin
      regs[aw_idx] <= merge(regs[aw_idx], w_data, w_strb);
    end
  end

  // Read data mux
  assign ar_idx = s_axi_araddr[8:2];
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ar_idx == `GSC_IDX_STATUS) begin
      rd_word = {30'h0, entry_fail, done};
    end else if (ar_idx == `GSC_IDX_FAILCODE) begin
      rd_word = {{(32-`GSC_FAIL_W){1'b0}}, fail_code};
    end else if (ar_idx == `GSC_IDX_CTRL) begin
      rd_word = regs[ar_idx] & ~(32'h1 << `GSC_CTL_START);
    end else if (is_mapped(ar_idx)) begin
      rd_word = regs[ar_idx];
    end
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= is_mapped(ar_idx) ? `GSC_RESP_OKAY : `GSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Guest image views
  gsc_word_t ctrl, ctl_zero, ctl_four, pt_hi, xfeat, zero_mask;
  logic long_guest, ug, v86;
  assign ctrl = regs[`GSC_IDX_CTRL];
  assign ctl_zero = regs[`GSC_IDX_CTL_ZERO];
  assign ctl_four = regs[`GSC_IDX_CTL_FOUR];
  assign pt_hi = regs[`GSC_IDX_PT_BASE_HI];
  assign xfeat = regs[`GSC_IDX_XFEAT];
  assign long_guest = ctrl[`GSC_CTL_LONG_GUEST];
  assign ug = ctrl[`GSC_CTL_UNRESTRICTED] && ctrl[`GSC_CTL_SECONDARY];
  assign v86 = regs[`GSC_IDX_FLAGS][`GSC_FLAGS_V86];

  // Bits that the fixed-value check covers
  assign zero_mask = ~((32'h1 << `GSC_Z_NWT) | (32'h1 << `GSC_Z_CDIS) |
    (ug ? ((32'h1 << `GSC_Z_PROT) | (32'h1 << `GSC_Z_PAGING)) : 32'h0));

  // Control, debug and model-specific image checks
  logic [7:0] mtt_bad;
  assign fail_vec[0] = ctl_zero[`GSC_Z_PAGING] && !ctl_zero[`GSC_Z_PROT];
  assign fail_vec[1] = ((((~ctl_zero) & regs[`GSC_IDX_ZERO_FX0]) |
    (ctl_zero & ~regs[`GSC_IDX_ZERO_FX1])) & zero_mask) != 32'h0;
  assign fail_vec[2] = (((~ctl_four) & regs[`GSC_IDX_FOUR_FX0]) |
    (ctl_four & ~regs[`GSC_IDX_FOUR_FX1])) != 32'h0;
  assign fail_vec[3] = long_guest &&
    !(ctl_zero[`GSC_Z_PAGING] && ctl_four[`GSC_F_PHYS_EXT]);
  assign fail_vec[4] = !long_guest && ctl_four[`GSC_F_CTX_ID];
  assign fail_vec[5] = ctrl[`GSC_CTL_LOAD_DBG] &&
    ((regs[`GSC_IDX_DBG_MSR] & DBG_RSVD) != 32'h0 ||
     regs[`GSC_IDX_DBG_REG_HI] != 32'h0);
  assign fail_vec[6] = pt_hi[31:20] != 12'h000 ||
    (pt_hi[19:0] & pa_over(regs[`GSC_IDX_PA_WIDTH])) != 20'h00000;
  for (genvar b = 0; b < 8; b++) begin : g_mtt
    logic [7:0] mt;
    assign mt = regs[b < 4 ? `GSC_IDX_MTT_LO : `GSC_IDX_MTT_HI][8*(b%4) +: 8];
    assign mtt_bad[b] = mt[7:3] != 5'h00 || mt[2:1] == 2'h1;
  end
  assign fail_vec[7] = ctrl[`GSC_CTL_LOAD_MTT] && (|mtt_bad);
  assign fail_vec[8] = ctrl[`GSC_CTL_LOAD_XFEAT] &&
    ((xfeat & XFEAT_RSVD) != 32'h0 || xfeat[`GSC_X_LM_ACTIVE] != long_guest ||
     (ctl_zero[`GSC_Z_PAGING] &&
      xfeat[`GSC_X_LM_ACTIVE] != xfeat[`GSC_X_LM_ENABLE]));

  // Per-segment field views
  gsc_word_t sel [8];
  gsc_word_t base_lo [8];
  gsc_word_t base_hi [8];
  gsc_word_t lim [8];
  gsc_word_t ar [8];
  logic [3:0] typ [8];
  logic [1:0] priv [8];
  logic usable [8];
  logic [5:0] v86_bad, attr_bad, gran_bad, data_bad;
  for (genvar s = 0; s < 8; s++) begin : g_fld
    localparam logic [6:0] BASE = 7'(`GSC_IDX_SEG0 + s * `GSC_SEG_STRIDE);
    assign sel[s] = regs[BASE + 7'(`GSC_FLD_SEL)];
    assign base_lo[s] = regs[BASE + 7'(`GSC_FLD_BASE_LO)];
    assign base_hi[s] = regs[BASE + 7'(`GSC_FLD_BASE_HI)];
    assign lim[s] = regs[BASE + 7'(`GSC_FLD_LIMIT)];
    assign ar[s] = regs[BASE + 7'(`GSC_FLD_AR)];
    assign typ[s] = ar[s][`GSC_AR_TYPE];
    assign priv[s] = ar[s][`GSC_AR_PRIV];
    assign usable[s] = !ar[s][`GSC_AR_UNUSABLE];
  end

  // Checks shared by the six code, stack and data segments
  for (genvar s = 0; s < 6; s++) begin : g_seg
    logic live;
    assign live = !v86 && (s == SEG_CODE || usable[s]);
    assign v86_bad[s] = v86 && (base_hi[s] != 32'h0 ||
      base_lo[s] != {12'h000, sel[s][15:0], 4'h0} ||
      lim[s] != `GSC_V86_LIMIT || ar[s] != `GSC_V86_AR);
    assign attr_bad[s] = live && (!ar[s][`GSC_AR_S] || !ar[s][`GSC_AR_P] ||
      (ar[s] & `GSC_AR_RSV_MASK) != 32'h0);
    assign gran_bad[s] = live && g_bad(lim[s], ar[s][`GSC_AR_G]);
    if (s == SEG_CODE || s == SEG_STACK) begin : g_nodata
      assign data_bad[s] = 1'b0;
    end else begin : g_data
      assign data_bad[s] = live && (!typ[s][0] || (typ[s][3] && !typ[s][1]) ||
        (!ug && typ[s] <= 4'hB && priv[s] < sel[s][1:0]));
    end
  end

  // Selector and base checks
  assign fail_vec[9] = sel[SEG_TASK][2] ||
    (usable[SEG_LOCAL_TABLE] && sel[SEG_LOCAL_TABLE][2]) ||
    (!v86 && !ug && sel[SEG_STACK][1:0] != sel[SEG_CODE][1:0]);
  assign fail_vec[10] = |v86_bad;
  assign fail_vec[11] = !canon(base_hi[SEG_TASK], base_lo[SEG_TASK]) ||
    !canon(base_hi[SEG_AUX_F], base_lo[SEG_AUX_F]) ||
    !canon(base_hi[SEG_AUX_G], base_lo[SEG_AUX_G]) ||
    (usable[SEG_LOCAL_TABLE] &&
     !canon(base_hi[SEG_LOCAL_TABLE], base_lo[SEG_LOCAL_TABLE])) ||
    base_hi[SEG_CODE] != 32'h0 ||
    (usable[SEG_STACK] && base_hi[SEG_STACK] != 32'h0) ||
    (usable[SEG_DATA] && base_hi[SEG_DATA] != 32'h0) ||
    (usable[SEG_EXTRA_E] && base_hi[SEG_EXTRA_E] != 32'h0);

  // Segment type, privilege, attribute, code-mode and granularity checks
  logic code_t3, code_nc, code_cf;
  assign code_t3 = typ[SEG_CODE] == 4'h3;
  assign code_nc = typ[SEG_CODE] == 4'h9 || typ[SEG_CODE] == 4'hB;
  assign code_cf = typ[SEG_CODE] == 4'hD || typ[SEG_CODE] == 4'hF;
  assign fail_vec[12] = !v86 && !(code_nc || code_cf || (ug && code_t3));
  assign fail_vec[13] = (!v86 && usable[SEG_STACK] &&
    typ[SEG_STACK] != 4'h3 && typ[SEG_STACK] != 4'h7) || (|data_bad);
  assign fail_vec[14] = |attr_bad;
  assign fail_vec[15] = !v86 && ((code_t3 && priv[SEG_CODE] != 2'h0) ||
    (code_nc && priv[SEG_CODE] != priv[SEG_STACK]) ||
    (code_cf && priv[SEG_CODE] > priv[SEG_STACK]));
  assign fail_vec[16] = !v86 && ((!ug && priv[SEG_STACK] != sel[SEG_STACK][1:0]) ||
    ((code_t3 || !ctl_zero[`GSC_Z_PROT]) && priv[SEG_STACK] != 2'h0));
  assign fail_vec[17] = 1'b0;
  assign fail_vec[18] = !v86 && long_guest && ar[SEG_CODE][`GSC_AR_L] &&
    ar[SEG_CODE][`GSC_AR_DB];
  assign fail_vec[19] = (|gran_bad) ||
    g_bad(lim[SEG_TASK], ar[SEG_TASK][`GSC_AR_G]) ||
    (usable[SEG_LOCAL_TABLE] &&
     g_bad(lim[SEG_LOCAL_TABLE], ar[SEG_LOCAL_TABLE][`GSC_AR_G]));

  // Task and local-table descriptor checks
  assign fail_vec[20] = (long_guest ? typ[SEG_TASK] != 4'hB :
    (typ[SEG_TASK] != 4'h3 && typ[SEG_TASK] != 4'hB)) ||
    ar[SEG_TASK][`GSC_AR_S] || !ar[SEG_TASK][`GSC_AR_P] ||
    ar[SEG_TASK][`GSC_AR_UNUSABLE] ||
    (ar[SEG_TASK] & `GSC_AR_RSV_MASK) != 32'h0;
  assign fail_vec[21] = usable[SEG_LOCAL_TABLE] && (typ[SEG_LOCAL_TABLE] != 4'h2 ||
    ar[SEG_LOCAL_TABLE][`GSC_AR_S] || !ar[SEG_LOCAL_TABLE][`GSC_AR_P] ||
    (ar[SEG_LOCAL_TABLE] & `GSC_AR_RSV_MASK) != 32'h0);

  // Start strobe from a control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_wr;
    end
  end

  // Verdict capture; set wins over the clear of a new start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      entry_fail <= 1'b0;
      fail_code <= '0;
    end else if (start_q) begin
      done <= 1'b1;
      entry_fail <= |fail_vec;
      fail_code <= fail_vec;
    end else if (start_wr) begin
      done <= 1'b0;
    end
  end

  // Verdict and reload pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      entry_done <= 1'b0;
      host_reload <= 1'b0;
    end else begin
      entry_done <= start_q;
      host_reload <= start_q && (|fail_vec);
    end
  end

  // Checks on the verdict path
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_paging_no_prot;
    start_q && ctl_zero[`GSC_Z_PAGING] && !ctl_zero[`GSC_Z_PROT] |=> entry_fail && fail_code[0];
  endproperty
  a_paging_no_prot: assert property (p_paging_no_prot)
    else $error("paging without protection not failed");

  property p_zero_mask;
    !zero_mask[`GSC_Z_NWT] && !zero_mask[`GSC_Z_CDIS] && (ug == !zero_mask[`GSC_Z_PROT]);
  endproperty
  a_zero_mask: assert property (p_zero_mask)
    else $error("fixed-bit mask wrong");

  property p_ug_gate;
    !ctrl[`GSC_CTL_SECONDARY] |-> !ug;
  endproperty
  a_ug_gate: assert property (p_ug_gate)
    else $error("unrestricted active without secondary controls");

  property p_long_guest;
    start_q && long_guest && !ctl_four[`GSC_F_PHYS_EXT] |=> entry_fail && fail_code[3];
  endproperty
  a_long_guest: assert property (p_long_guest)
    else $error("long guest without address extension passed");

  property p_mtt_byte;
    start_q && ctrl[`GSC_CTL_LOAD_MTT] && regs[`GSC_IDX_MTT_HI][31:24] == 8'h02
      |=> fail_code[7];
  endproperty
  a_mtt_byte: assert property (p_mtt_byte)
    else $error("illegal memory type accepted");

  property p_v86_limit;
    start_q && v86 && lim[SEG_CODE] != `GSC_V86_LIMIT |=> entry_fail;
  endproperty
  a_v86_limit: assert property (p_v86_limit)
    else $error("virtual-8086 limit not checked");

  property p_code_t3;
    start_q && !v86 && !ug && code_t3 |=> entry_fail && fail_code[12];
  endproperty
  a_code_t3: assert property (p_code_t3)
    else $error("code type 3 accepted without unrestricted");

  property p_task_unusable;
    start_q && ar[SEG_TASK][`GSC_AR_UNUSABLE] |=> entry_fail;
  endproperty
  a_task_unusable: assert property (p_task_unusable)
    else $error("unusable task segment accepted");

  property p_reload;
    entry_done |-> (host_reload == entry_fail);
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload does not follow failure");

  property p_verdict;
    start_q |=> entry_done && done && (entry_fail == (fail_code != '0)) ##1 !entry_done;
  endproperty
  a_verdict: assert property (p_verdict)
    else $error("verdict pulse or flag wrong");

  c_pass: cover property (entry_done && !entry_fail);
  c_fail: cover property (entry_done && host_reload);
  c_v86_pass: cover property (start_q && v86 ##1 !entry_fail);

endmodule : gsc_guest_state_entry_checker

/* File: core/gsc_map.svh */
// Register map, field positions, reset values and constants of the entry checker
`ifndef GSC_MAP_SVH
`define GSC_MAP_SVH
`define GSC_NREGS 128
`define GSC_IDX_CTRL 7'h00
`define GSC_IDX_STATUS 7'h01
`define GSC_IDX_FAILCODE 7'h02
`define GSC_IDX_CTL_ZERO 7'h03
`define GSC_IDX_CTL_FOUR 7'h04
`define GSC_IDX_PT_BASE_LO 7'h05
`define GSC_IDX_PT_BASE_HI 7'h06
`define GSC_IDX_DBG_REG_HI 7'h07
`define GSC_IDX_DBG_MSR 7'h08
`define GSC_IDX_MTT_LO 7'h09
`define GSC_IDX_MTT_HI 7'h0A
`define GSC_IDX_XFEAT 7'h0B
`define GSC_IDX_FLAGS 7'h0C
`define GSC_IDX_ZERO_FX0 7'h0D
`define GSC_IDX_ZERO_FX1 7'h0E
`define GSC_IDX_FOUR_FX0 7'h0F
`define GSC_IDX_FOUR_FX1 7'h10
`define GSC_IDX_PA_WIDTH 7'h11
`define GSC_IDX_LAST 7'h11
`define GSC_IDX_SEG0 7'h20
`define GSC_IDX_SEG_END 7'h60
`define GSC_SEG_STRIDE 8
`define GSC_SEG_FIELDS 3'h5
`define GSC_FLD_SEL 0
`define GSC_FLD_BASE_LO 1
`define GSC_FLD_BASE_HI 2
`define GSC_FLD_LIMIT 3
`define GSC_FLD_AR 4
`define GSC_CTL_START 0
`define GSC_CTL_LONG_GUEST 1
`define GSC_CTL_LOAD_DBG 2
`define GSC_CTL_LOAD_MTT 3
`define GSC_CTL_LOAD_XFEAT 4
`define GSC_CTL_UNRESTRICTED 5
`define GSC_CTL_SECONDARY 6
`define GSC_Z_PROT 0
`define GSC_Z_NWT 29
`define GSC_Z_CDIS 30
`define GSC_Z_PAGING 31
`define GSC_F_PHYS_EXT 5
`define GSC_F_CTX_ID 17
`define GSC_X_LM_ENABLE 8
`define GSC_X_LM_ACTIVE 10
`define GSC_FLAGS_V86 17
`define GSC_AR_TYPE 3:0
`define GSC_AR_PRIV 6:5
`define GSC_AR_S 4
`define GSC_AR_P 7
`define GSC_AR_L 13
`define GSC_AR_DB 14
`define GSC_AR_G 15
`define GSC_AR_UNUSABLE 16
`define GSC_AR_RSV_MASK 32'hFFFE_0F00
`define GSC_V86_LIMIT 32'h0000_FFFF
`define GSC_V86_AR 32'h0000_00F3
`define GSC_FX1_RST 32'hFFFF_FFFF
`define GSC_PA_WIDTH_RST 32'h0000_0024
`define GSC_FAIL_W 22
`define GSC_RESP_OKAY 2'h0
`define GSC_RESP_SLVERR 2'h2
`endif

/* File: core/gsc_pkg.sv */
// Types shared by the guest-state entry checker
package gsc_pkg;
  typedef logic [31:0] gsc_word_t;
  typedef enum logic [2:0] {
    SEG_EXTRA_E = 3'h0,
    SEG_CODE = 3'h1,
    SEG_STACK = 3'h2,
    SEG_DATA = 3'h3,
    SEG_AUX_F = 3'h4,
    SEG_AUX_G = 3'h5,
    SEG_LOCAL_TABLE = 3'h6,
    SEG_TASK = 3'h7
  } gsc_seg_t;
endpackage : gsc_pkg

/* File: sim/gsc_guest_state_entry_checker_tb.sv */
// Register-level testbench for the guest-state entry checker
`timescale 1ns/1ps
`include "gsc_map.svh"
module gsc_guest_state_entry_checker_tb
  import gsc_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, entry_done, entry_fail, host_reload;
  logic [8:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int v;

  gsc_guest_state_entry_checker gsc_guest_state_entry_checker_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .entry_done(entry_done),
    .entry_fail(entry_fail), .host_reload(host_reload)
  );

  // Clock at 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Verdict and end of run
  task end_sim;
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t run timed out", $time);
      end_sim();
    end
  end

  // One comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write cycle, address and data offered together
  task wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask : wr

  // Full-word write expecting OKAY
  task w(input logic [8:0] a, input logic [31:0] d);
    wr(a, d, 4'hF, `GSC_RESP_OKAY);
  endtask : w

  // Read cycle with expected data and response
  task rd(input logic [8:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd

  // Start a check and compare verdict, reload pulse, code and status
  task go(input logic [6:0] c, input logic [21:0] e);
    int k;
    w(9'h000, {25'h0, c} | 32'h1);
    for (k = 0; k < 20 && entry_done !== 1'b1; k++) @(posedge aclk);
    chk({31'h0, entry_done}, 32'h1);
    chk({31'h0, entry_fail}, {31'h0, |e});
    chk({31'h0, host_reload}, {31'h0, |e});
    rd(9'h008, {10'h0, e}, `GSC_RESP_OKAY);
    rd(9'h004, {30'h0, |e, 1'b1}, `GSC_RESP_OKAY);
  endtask : go

  // Plant a bad value, check, put the good value back
  task flt(input logic [8:0] a, input logic [31:0] bad, input logic [31:0] good,
           input logic [6:0] c, input logic [21:0] e);
    w(a, bad);
    go(c, e);
    w(a, good);
  endtask : flt

  // Main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = '0; s_axi_araddr = '0;
    s_axi_wdata = '0; s_axi_wstrb = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, unmapped and read-only places, strobes
    rd(9'h038, 32'hFFFF_FFFF, `GSC_RESP_OKAY);
    rd(9'h040, 32'hFFFF_FFFF, `GSC_RESP_OKAY);
    rd(9'h044, 32'h0000_0024, `GSC_RESP_OKAY);
    rd(9'h094, 32'h0, `GSC_RESP_SLVERR);
    wr(9'h048, 32'h1, 4'hF, `GSC_RESP_SLVERR);
    wr(9'h004, 32'h3, 4'hF, `GSC_RESP_OKAY);
    rd(9'h004, 32'h0, `GSC_RESP_OKAY);
    wr(9'h014, 32'hAABB_CCDD, 4'h5, `GSC_RESP_OKAY);
    rd(9'h014, 32'h00BB_00DD, `GSC_RESP_OKAY);
    w(9'h014, 32'h0);
    // Protected flat guest that passes every check
    w(9'h00C, 32'h1); w(9'h0A0, 32'h8); w(9'h0AC, 32'hFFFF_FFFF); w(9'h0B0, 32'hC09B);
    w(9'h0C0, 32'h10); w(9'h0CC, 32'hFFFF_FFFF); w(9'h0D0, 32'hC093);
    w(9'h090, 32'h10000); w(9'h0F0, 32'h10000); w(9'h110, 32'h10000);
    w(9'h130, 32'h10000); w(9'h150, 32'h10000);
    w(9'h160, 32'h18); w(9'h16C, 32'h67); w(9'h170, 32'h8B);
    go(7'h00, 22'h0);
    flt(9'h00C, 32'h8000_0000, 32'h1, 7'h00, 22'h1);
    w(9'h034, 32'h8000_0001);
    go(7'h00, 22'h2);
    go(7'h60, 22'h0);
    go(7'h20, 22'h2);
    flt(9'h034, 32'h6000_0000, 32'h0, 7'h00, 22'h0);
    flt(9'h03C, 32'h20, 32'h0, 7'h00, 22'h4);
    go(7'h02, 22'h8);
    flt(9'h010, 32'h0002_0000, 32'h0, 7'h00, 22'h10);
    flt(9'h01C, 32'h1, 32'h0, 7'h04, 22'h20);
    flt(9'h01C, 32'h1, 32'h0, 7'h00, 22'h0);
    flt(9'h020, 32'h4, 32'h0, 7'h04, 22'h20);
    flt(9'h018, 32'h10, 32'h0, 7'h00, 22'h40);
    flt(9'h018, 32'h8, 32'h0, 7'h00, 22'h0);
    flt(9'h018, 32'h0010_0000, 32'h0, 7'h00, 22'h40);
    for (v = 0; v < 8; v++) begin
      flt(9'h028, v << 24, 32'h0, 7'h08, (v == 2 || v == 3) ? 22'h80 : 22'h0);
    end
    flt(9'h02C, 32'h400, 32'h0, 7'h10, 22'h100);
    flt(9'h02C, 32'h2, 32'h0, 7'h10, 22'h100);
    flt(9'h160, 32'h1C, 32'h18, 7'h00, 22'h200);
    flt(9'h0C0, 32'h13, 32'h10, 7'h00, 22'h10200);
    flt(9'h140, 32'h4, 32'h0, 7'h00, 22'h0);
    w(9'h150, 32'h82);
    flt(9'h140, 32'h4, 32'h0, 7'h00, 22'h200);
    w(9'h150, 32'h10000);
    flt(9'h030, 32'h0002_0000, 32'h0, 7'h00, 22'h400);
    flt(9'h0A8, 32'h1, 32'h0, 7'h00, 22'h800);
    flt(9'h0E8, 32'h1, 32'h0, 7'h00, 22'h0);
    flt(9'h168, 32'h8000, 32'h0, 7'h00, 22'h800);
    flt(9'h0B0, 32'hC093, 32'hC09B, 7'h00, 22'h1000);
    flt(9'h0B0, 32'hC093, 32'hC09B, 7'h60, 22'h0);
    flt(9'h0D0, 32'hC091, 32'hC093, 7'h00, 22'h2000);
    flt(9'h0F0, 32'h99, 32'h10000, 7'h00, 22'h2000);
    flt(9'h0F0, 32'h9B, 32'h10000, 7'h00, 22'h0);
    w(9'h0E0, 32'h3);
    flt(9'h0F0, 32'h93, 32'h10000, 7'h00, 22'h2000);
    flt(9'h0F0, 32'h93, 32'h10000, 7'h60, 22'h0);
    w(9'h0E0, 32'h0);
    flt(9'h0B0, 32'hC01B, 32'hC09B, 7'h00, 22'h4000);
    flt(9'h0B0, 32'hC19B, 32'hC09B, 7'h00, 22'h4000);
    flt(9'h0B0, 32'hC0FB, 32'hC09B, 7'h00, 22'h8000);
    flt(9'h0B0, 32'hC09F, 32'hC09B, 7'h00, 22'h0);
    flt(9'h0AC, 32'hFFFF_F000, 32'hFFFF_FFFF, 7'h00, 22'h80000);
    flt(9'h0B0, 32'h409B, 32'hC09B, 7'h00, 22'h80000);
    flt(9'h170, 32'h89, 32'h8B, 7'h00, 22'h100000);
    flt(9'h170, 32'h83, 32'h8B, 7'h00, 22'h0);
    flt(9'h150, 32'h82, 32'h10000, 7'h00, 22'h0);
    flt(9'h150, 32'h83, 32'h10000, 7'h00, 22'h200000);
    // Long-mode guest
    w(9'h00C, 32'h8000_0001); w(9'h010, 32'h20);
    flt(9'h0B0, 32'hE09B, 32'hC09B, 7'h02, 22'h40000);
    flt(9'h0B0, 32'hA09B, 32'hC09B, 7'h02, 22'h0);
    flt(9'h02C, 32'h500, 32'h0, 7'h12, 22'h0);
    flt(9'h02C, 32'h400, 32'h0, 7'h12, 22'h100);
    flt(9'h170, 32'h83, 32'h8B, 7'h02, 22'h100000);
    // Second reset clears status and images
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(9'h004, 32'h0, `GSC_RESP_OKAY);
    rd(9'h00C, 32'h0, `GSC_RESP_OKAY);
    end_sim();
  end
endmodule : gsc_guest_state_entry_checker_tb
